// ### dv/trf_formatter_tb.sv
// Bench for the temperature result formatter: conversion table, then edge cases.
// Assumes results show one cycle after the strobe and reset clears to zero.
`default_nettype none
module trf_formatter_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0, rst = 1'b1, clk_en = 1'b1, range_sel = 1'b0;
  trf_pkg::trf_conv_t conv = '0;
  trf_pkg::trf_result_t local_res, remote_res;
  logic ext_active;
  int n_errors = 0, n_tests = 0;
  // Range, channel, raw sixteenths, expected bytes
  logic [34:0] rows [14] = '{
    {2'b00, 17'h00198, 16'h1980}, {2'b01, 17'h1FFB8, 16'h0080},
    {2'b00, 17'h00C80, 16'h7F00}, {2'b11, 17'h00001, 16'h4010},
    {2'b10, 17'h1FC00, 16'h0000}, {2'b10, 17'h00BFF, 16'hFFF0},
    {2'b11, 17'h00FA0, 16'hFF00}, {2'b11, 17'h1F9C0, 16'h0000},
    {2'b01, 17'h00320, 16'h3200}, {2'b00, 17'h1FFB8, 16'h0080},
    {2'b10, 17'h1F9C0, 16'h0000}, {2'b10, 17'h00FA0, 16'hFF00},
    {2'b10, 17'h1FE70, 16'h2700}, {2'b10, 17'h00198, 16'h5980}};
  // 4 ns period
  always #2 mclk = ~mclk;
  trf_formatter dut_u (.mclk(mclk), .rst(rst), .clk_en(clk_en), .range_sel(range_sel),
    .conv(conv), .local_res(local_res), .remote_res(remote_res), .ext_active(ext_active));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  // One strobe, then sample once its edge has landed
  task automatic send(input logic rs, input logic ch, input logic [16:0] t);
    @(posedge mclk);
    range_sel <= rs;
    conv <= {1'b1, ch, t};
    @(posedge mclk);
    conv.valid <= 1'b0;
    #1;
  endtask
  task automatic report_and_stop;
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Run far shorter than this in practice
  initial begin
    repeat (2000) @(posedge mclk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk(local_res, 16'h0000);
    chk_flag(ext_active, 1'b0);
    foreach (rows[i]) begin
      send(rows[i][34], rows[i][33], rows[i][32:16]);
      chk(rows[i][33] ? remote_res : local_res, rows[i][15:0]);
      chk_flag(ext_active, rows[i][34]);
    end
    // Range flip alone must leave stored bytes
    range_sel <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(local_res, 16'h5980);
    chk_flag(ext_active, 1'b1);
    // Frozen clock enable drops the strobe
    clk_en <= 1'b0;
    send(1'b0, 1'b0, 17'h00010);
    chk(local_res, 16'h5980);
    clk_en <= 1'b1;
    // Back to back, both channels at the clamp edge
    @(posedge mclk);
    conv <= {1'b1, 1'b0, 17'h007F0};
    @(posedge mclk);
    conv <= {1'b1, 1'b1, 17'h00808};
    @(posedge mclk);
    conv.valid <= 1'b0;
    #1;
    chk(local_res, 16'h7F00);
    chk(remote_res, 16'h7F80);
    chk_flag(ext_active, 1'b0);
    rst <= 1'b1;
    @(posedge mclk);
    #1;
    chk(remote_res, 16'h0000);
    chk(local_res, 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ### hw/trf_formatter.sv
// Temperature result formatter: turns conversion-core results into register bytes.
// Assumes conversion results arrive synchronous to mclk, one per valid pulse.
`default_nettype none
module trf_formatter (
  input wire logic mclk, // 250 MHz device clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic clk_en, // Freezes all state while low unless rst is high
  input wire logic range_sel, // Config bit 2: extended format when high
  input wire trf_pkg::trf_conv_t conv, // Conversion result with strobe
  output trf_pkg::trf_result_t local_res, // Local channel result bytes
  output trf_pkg::trf_result_t remote_res, // Remote channel result bytes
  output logic ext_active // Format of the most recent taken conversion, either channel
);
  localparam int W = trf_pkg::TEMP_W;

  // Saturate whole degrees to the active range, then offset for extended
  function automatic logic [7:0] fmt_high(input logic signed [W-1:0] deg, input logic ext);
    logic signed [W-1:0] v;
    v = deg;
    if (ext) begin
      if (v < trf_pkg::EXT_MIN) v = trf_pkg::EXT_MIN;
      if (v > trf_pkg::EXT_MAX) v = trf_pkg::EXT_MAX;
      v = v + trf_pkg::EXT_OFFSET;
    end else begin
      if (v < trf_pkg::STD_MIN) v = trf_pkg::STD_MIN;
      if (v > trf_pkg::STD_MAX) v = trf_pkg::STD_MAX;
    end
    return v[7:0];
  endfunction

  logic ext_q, ext_d;
  trf_pkg::trf_result_t res_q [trf_pkg::NCHAN];
  trf_pkg::trf_result_t res_d [trf_pkg::NCHAN];

  // Range latched only on a conversion so stored bytes never change format mid-read
  always_comb begin
    ext_d = ext_q;
    if (conv.valid) ext_d = range_sel;
  end

  genvar g;
  generate
    for (g = 0; g < trf_pkg::NCHAN; g++) begin : g_chan
      // Next value: new conversion uses the range selected at that moment
      always_comb begin
        res_d[g] = res_q[g];
        if (conv.valid && (conv.chan == g[0])) begin
          res_d[g].high_byte = fmt_high(conv.temp[W+trf_pkg::FRAC_W-1:trf_pkg::FRAC_W],
                                        range_sel);
          res_d[g].low_byte = {conv.temp[trf_pkg::FRAC_W-1:0], 4'h0};
        end
      end
      // Register stage
      always_ff @(posedge mclk) begin
        if (rst) begin
          res_q[g] <= '{high_byte: trf_pkg::RESULT_RST, low_byte: trf_pkg::RESULT_RST};
        end else if (clk_en) begin
          res_q[g] <= res_d[g];
        end
      end
    end
  endgenerate

  // Format state register, standard after reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      ext_q <= trf_pkg::RANGE_RST;
    end else if (clk_en) begin
      ext_q <= ext_d;
    end
  end

  assign local_res = res_q[0];
  assign remote_res = res_q[1];
  assign ext_active = ext_q;

  logic signed [W-1:0] cdeg;
  assign cdeg = conv.temp[W+trf_pkg::FRAC_W-1:trf_pkg::FRAC_W];

  // Strobes as the register stage takes them, one per channel
  sequence s_conv_local;
    clk_en && conv.valid && !conv.chan;
  endsequence

  sequence s_conv_remote;
    clk_en && conv.valid && conv.chan;
  endsequence

  // Format asked for at the strobe
  sequence s_std_req;
    !range_sel;
  endsequence

  sequence s_ext_req;
    range_sel;
  endsequence

  // Local channel, standard format
  AST_STD_NEG: assert property (@(posedge mclk) disable iff (rst)
    (s_conv_local and s_std_req and (cdeg < 0))
    |=> local_res.high_byte == 8'h00)
    else $error("standard negative not zero");

  AST_STD_SAT: assert property (@(posedge mclk) disable iff (rst)
    (s_conv_local and s_std_req and (cdeg > 127))
    |=> local_res.high_byte == 8'h7F)
    else $error("standard not saturated");

  AST_STD_PASS: assert property (@(posedge mclk) disable iff (rst)
    (s_conv_local and s_std_req and (cdeg >= 0 && cdeg <= 127))
    |=> local_res.high_byte == $past(cdeg[7:0]))
    else $error("standard value wrong");

  // Local channel, extended format
  AST_EXT_OFS: assert property (@(posedge mclk) disable iff (rst)
    (s_conv_local and s_ext_req and (cdeg >= -64 && cdeg <= 191))
    |=> local_res.high_byte == 8'($past(cdeg) + 64))
    else $error("extended offset wrong");

  AST_EXT_SAT: assert property (@(posedge mclk) disable iff (rst)
    (s_conv_local and s_ext_req and (cdeg > 191))
    |=> local_res.high_byte == 8'hFF)
    else $error("extended not saturated high");

  AST_EXT_LOW: assert property (@(posedge mclk) disable iff (rst)
    (s_conv_local and s_ext_req and (cdeg < -64))
    |=> local_res.high_byte == 8'h00)
    else $error("extended not saturated low");

  // Remote channel, standard format
  AST_RSTD_NEG: assert property (@(posedge mclk) disable iff (rst)
    (s_conv_remote and s_std_req and (cdeg < 0))
    |=> remote_res.high_byte == 8'h00)
    else $error("remote standard negative not zero");

  AST_RSTD_SAT: assert property (@(posedge mclk) disable iff (rst)
    (s_conv_remote and s_std_req and (cdeg > 127))
    |=> remote_res.high_byte == 8'h7F)
    else $error("remote standard not saturated");

  AST_RSTD_PASS: assert property (@(posedge mclk) disable iff (rst)
    (s_conv_remote and s_std_req and (cdeg >= 0 && cdeg <= 127))
    |=> remote_res.high_byte == $past(cdeg[7:0]))
    else $error("remote standard value wrong");

  // Remote channel, extended format
  AST_REXT_OFS: assert property (@(posedge mclk) disable iff (rst)
    (s_conv_remote and s_ext_req and (cdeg >= -64 && cdeg <= 191))
    |=> remote_res.high_byte == 8'($past(cdeg) + 64))
    else $error("remote extended offset wrong");

  AST_REXT_SAT: assert property (@(posedge mclk) disable iff (rst)
    (s_conv_remote and s_ext_req and (cdeg > 191))
    |=> remote_res.high_byte == 8'hFF)
    else $error("remote extended not saturated high");

  AST_REXT_LOW: assert property (@(posedge mclk) disable iff (rst)
    (s_conv_remote and s_ext_req and (cdeg < -64))
    |=> remote_res.high_byte == 8'h00)
    else $error("remote extended not saturated low");

  // Fraction kept even when the high byte saturates
  AST_LFRAC: assert property (@(posedge mclk) disable iff (rst)
    s_conv_local
    |=> local_res.low_byte == {$past(conv.temp[3:0]), 4'h0})
    else $error("local fraction misplaced");

  // A local result must never disturb the remote bytes
  AST_CHAN_SEP: assert property (@(posedge mclk) disable iff (rst)
    s_conv_local |=> $stable(remote_res))
    else $error("local conversion touched remote");

  // Frozen enable holds every stored value
  AST_FREEZE: assert property (@(posedge mclk) disable iff (rst)
    !clk_en |=> $stable(local_res) && $stable(remote_res) && $stable(ext_active))
    else $error("state moved while frozen");

  // Format status moves only with a taken conversion
  AST_IDLE_FMT: assert property (@(posedge mclk) disable iff (rst)
    clk_en && !conv.valid |=> $stable(ext_active))
    else $error("format changed without conversion");

  // Reset wins over the enable and clears everything
  AST_RST_CLR: assert property (@(posedge mclk)
    rst |=> local_res == 16'h0000 && remote_res == 16'h0000 && !ext_active)
    else $error("reset did not clear results");

  AST_FRAC: assert property (@(posedge mclk) disable iff (rst)
    clk_en && conv.valid && conv.chan
    |=> remote_res.low_byte == {$past(conv.temp[3:0]), 4'h0})
    else $error("fraction misplaced");
  AST_NIB: assert property (@(posedge mclk) disable iff (rst)
    local_res.low_byte[3:0] == 4'h0 && remote_res.low_byte[3:0] == 4'h0)
    else $error("low nibble nonzero");
  AST_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !conv.valid && clk_en && $changed(range_sel)
    |=> $stable(local_res) && $stable(remote_res) && $stable(ext_active))
    else $error("range change altered results");
  AST_FMT: assert property (@(posedge mclk) disable iff (rst)
    clk_en && conv.valid |=> ext_active == $past(range_sel))
    else $error("format not latched");
endmodule
`default_nettype wire

// ### hw/trf_pkg.sv
// Package for the temperature result formatter: formats, widths, field layouts.
// Assumes a single mclk domain with synchronous active-high reset.
// Overview of operation
// - Standard format by default, 0..127 unsigned
// - Standard format: negative temperatures store 00h
// - Standard format: saturate above 127 at 7Fh
// - Range-select high selects extended format
// - Range change applies at next conversion
// - Extended format adds offset 64 (0C = 40h)
// - Extended spans -64..191 as 00h..FFh
// - Two bytes per channel, high byte whole degrees
// - Low byte holds fixed sixteenth-degree fraction
// - Fraction in upper nibble, lower nibble zero
`default_nettype none
package trf_pkg;
  // Raw result: signed whole degrees plus 4 fraction bits (sixteenths)
  localparam int TEMP_W = 13;
  localparam int FRAC_W = 4;
  localparam int NCHAN = 2;
  localparam logic signed [TEMP_W-1:0] STD_MIN = 13'sh0000;
  localparam logic signed [TEMP_W-1:0] STD_MAX = 13'sh007F;
  localparam logic signed [TEMP_W-1:0] EXT_MIN = -13'sh0040;
  localparam logic signed [TEMP_W-1:0] EXT_MAX = 13'sh00BF;
  localparam logic signed [TEMP_W-1:0] EXT_OFFSET = 13'sh0040;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic RANGE_RST = 1'b0;

  typedef struct packed {
    logic [7:0] high_byte;
    logic [7:0] low_byte;
  } trf_result_t;

  typedef struct packed {
    logic valid;
    logic chan;
    logic signed [TEMP_W+FRAC_W-1:0] temp;
  } trf_conv_t;
endpackage
`default_nettype wire
